/* rtl/wrb_pkg.sv */
// Purpose: constants for the wireless receiver host register bank
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: register indices are byte offsets of the device map; APB address is index * 4
//
// Functional notes
// R1 - The charge level register is 8-bit read/write, resets to zero and is sent unchanged.
// R2 - The termination code register is 8-bit read/write, resets to zero and goes into the termination packet.
// R3 - Writing one to command bit 5 releases the asserted interrupt pin.
// R4 - Command bit 4 sends exactly one charge-level packet with the charge level, then clears itself.
// R5 - Command bit 3 sends a power-termination packet with the termination code, then clears itself.
// R6 - Command bit 1 inverts the regulator on/off state once, then clears itself.
// R7 - Output voltage sample is low byte then top nibble in bits 3:0 of the next byte, upper nibble zero.
// R8 - Software converts the output voltage sample to volts as sample * 6 * 2.1 / 4095.
// R9 - Rectifier voltage sample is low byte then top nibble; volts are sample * 10 * 2.1 / 4095.
// R10 - Output current is a 16-bit milliamp value, low byte at the lower address.
// R11 - Die temperature is a 12-bit sample, low byte first; Celsius is (sample - 1350) * 83 / 444 - 273.
// R12 - Frequency count is 16 bits, high byte at the lower address; kHz is 64 * 6000 / count.
// R13 - A read-only signed 8-bit horizontal coil offset is presented.
// R14 - A read-only signed 8-bit vertical coil offset is presented.
// R15 - The active-low interrupt pin is low while any status bit and its enable bit are both one.
// R16 - Reserved command bits ignore writes and read zero; multi-byte samples are captured coherently.

package wrb_pkg;

    // ----------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_INT_STAT = 8'h36;
    localparam logic [7:0] IDX_INT_EN = 8'h38;
    localparam logic [7:0] IDX_CHARGE = 8'h3A;
    localparam logic [7:0] IDX_TERM = 8'h3B;
    localparam logic [7:0] IDX_VOUT_LO = 8'h3C;
    localparam logic [7:0] IDX_VOUT_HI = 8'h3D;
    localparam logic [7:0] IDX_RECT_LO = 8'h40;
    localparam logic [7:0] IDX_RECT_HI = 8'h41;
    localparam logic [7:0] IDX_IOUT_LO = 8'h44;
    localparam logic [7:0] IDX_IOUT_HI = 8'h45;
    localparam logic [7:0] IDX_TEMP_LO = 8'h46;
    localparam logic [7:0] IDX_TEMP_HI = 8'h47;
    localparam logic [7:0] IDX_FREQ_HI = 8'h48;
    localparam logic [7:0] IDX_FREQ_LO = 8'h49;
    localparam logic [7:0] IDX_ALIGN_H = 8'h4B;
    localparam logic [7:0] IDX_ALIGN_V = 8'h4C;
    localparam logic [7:0] IDX_CMD = 8'h4E;

    localparam logic [11:0] ADDR_INT_STAT = {2'h0, IDX_INT_STAT, 2'h0};
    localparam logic [11:0] ADDR_INT_EN = {2'h0, IDX_INT_EN, 2'h0};
    localparam logic [11:0] ADDR_CHARGE = {2'h0, IDX_CHARGE, 2'h0};
    localparam logic [11:0] ADDR_TERM = {2'h0, IDX_TERM, 2'h0};
    localparam logic [11:0] ADDR_VOUT_LO = {2'h0, IDX_VOUT_LO, 2'h0};
    localparam logic [11:0] ADDR_VOUT_HI = {2'h0, IDX_VOUT_HI, 2'h0};
    localparam logic [11:0] ADDR_RECT_LO = {2'h0, IDX_RECT_LO, 2'h0};
    localparam logic [11:0] ADDR_RECT_HI = {2'h0, IDX_RECT_HI, 2'h0};
    localparam logic [11:0] ADDR_IOUT_LO = {2'h0, IDX_IOUT_LO, 2'h0};
    localparam logic [11:0] ADDR_IOUT_HI = {2'h0, IDX_IOUT_HI, 2'h0};
    localparam logic [11:0] ADDR_TEMP_LO = {2'h0, IDX_TEMP_LO, 2'h0};
    localparam logic [11:0] ADDR_TEMP_HI = {2'h0, IDX_TEMP_HI, 2'h0};
    localparam logic [11:0] ADDR_FREQ_HI = {2'h0, IDX_FREQ_HI, 2'h0};
    localparam logic [11:0] ADDR_FREQ_LO = {2'h0, IDX_FREQ_LO, 2'h0};
    localparam logic [11:0] ADDR_ALIGN_H = {2'h0, IDX_ALIGN_H, 2'h0};
    localparam logic [11:0] ADDR_ALIGN_V = {2'h0, IDX_ALIGN_V, 2'h0};
    localparam logic [11:0] ADDR_CMD = {2'h0, IDX_CMD, 2'h0};

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CMD_CLRINT_BIT = 5;
    localparam int CMD_CHARGE_BIT = 4;
    localparam int CMD_TERM_BIT = 3;
    localparam int CMD_FLIP_BIT = 1;
    localparam int INT_VOUT_BIT = 7;
    localparam int INT_TEMP_BIT = 2;
    localparam int INT_RECT_BIT = 1;
    localparam int INT_OC_BIT = 0;
    localparam logic [7:0] INT_MASK = 8'h87;

    // Measurement snapshot layout
    localparam int MEAS_W = 84;
    localparam int VOUT_POS = 0;
    localparam int RECT_POS = 12;
    localparam int IOUT_POS = 24;
    localparam int TEMP_POS = 40;
    localparam int FREQ_POS = 52;
    localparam int ALGH_POS = 68;
    localparam int ALGV_POS = 76;

    // ----------------------------------------
    // Reset values and packet kinds
    // ----------------------------------------
    localparam logic [7:0] CHARGE_RST = 8'h00;
    localparam logic [7:0] TERM_RST = 8'h00;
    localparam logic [7:0] INT_EN_RST = 8'h07;
    localparam logic REG_ON_RST = 1'b1;
    localparam logic PKT_CHARGE = 1'b0;
    localparam logic PKT_TERM = 1'b1;

endpackage

/* rtl/wrb_snapshot.sv */
// Purpose: coherent capture of all measurement words
// Assumes: capture is a single-cycle strobe from the measurement side
// Notes: every field is taken on the same edge, so split bytes always match
`timescale 1ns/1ns

module wrb_snapshot
    import wrb_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Capture
    input wire logic capture,
    input wire logic [MEAS_W-1:0] meas_in,
    output logic [MEAS_W-1:0] meas_q
);

    // ----------------------------------------
    // Snapshot register
    // ----------------------------------------
    logic [MEAS_W-1:0] meas_d;

    // Whole sample in one edge, never byte by byte
    assign meas_d = capture ? meas_in : meas_q; // R16

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meas_q <= '0;
        end else begin
            meas_q <= meas_d;
        end
    end

endmodule

/* rtl/wrb_regbank.sv */
// Purpose: host register bank of the wireless power receiver, APB slave
// Assumes: packet link to the transmitter takes one byte per valid/ready handshake
// Notes: zero-wait APB; read data is prepared in the setup cycle
//
// Our own choice: the APB register port.
`timescale 1ns/1ns

module wrb_regbank
    import wrb_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Measurements
    input wire logic meas_strobe,
    input wire logic [11:0] out_volt_sample,
    input wire logic [11:0] rect_volt_sample,
    input wire logic [15:0] out_current,
    input wire logic [11:0] die_temp_sample,
    input wire logic [15:0] freq_count,
    input wire logic [7:0] coil_offset_horiz,
    input wire logic [7:0] coil_offset_vert,
    // Fault levels
    input wire logic over_temp,
    input wire logic rect_over_volt,
    input wire logic over_current,
    // Packet link to transmitter
    output logic pkt_valid,
    output logic pkt_kind,
    output logic [7:0] pkt_data,
    input wire logic pkt_ready,
    // Regulator and interrupt
    output logic regulator_on,
    output logic irq_b
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] charge_q, charge_d;
    logic [7:0] term_code_q, term_code_d;
    logic [7:0] int_stat_q, int_stat_d;
    logic [7:0] int_en_q, int_en_d;
    logic cmd_chg_q, cmd_chg_d;
    logic cmd_term_q, cmd_term_d;
    logic cmd_flip_q, cmd_flip_d;
    logic reg_on_q, reg_on_d;
    logic pkt_valid_q, pkt_valid_d;
    logic pkt_kind_q, pkt_kind_d;
    logic [7:0] pkt_data_q, pkt_data_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q;
    logic pslverr_q, pslverr_d;
    logic irq_b_q;
    logic ot_q, ov_q, oc_q;
    logic [MEAS_W-1:0] meas_in;
    logic [MEAS_W-1:0] meas_q;

    // ----------------------------------------
    // Measurement capture
    // ----------------------------------------
    assign meas_in = {coil_offset_vert, coil_offset_horiz, freq_count, die_temp_sample,
                      out_current, rect_volt_sample, out_volt_sample};

    wrb_snapshot u_snap (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .capture(meas_strobe),
        .meas_in(meas_in),
        .meas_q(meas_q)
    );

    wire [11:0] vout_s = meas_q[VOUT_POS +: 12];
    wire [11:0] rect_s = meas_q[RECT_POS +: 12];
    wire [15:0] iout_s = meas_q[IOUT_POS +: 16];
    wire [11:0] temp_s = meas_q[TEMP_POS +: 12];
    wire [15:0] freq_s = meas_q[FREQ_POS +: 16];
    wire [7:0] algh_s = meas_q[ALGH_POS +: 8];
    wire [7:0] algv_s = meas_q[ALGV_POS +: 8];

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_q;
    wire wr_acc = acc & pwrite;
    wire rd_acc = acc & ~pwrite;
    wire wr_charge = wr_acc & (paddr == ADDR_CHARGE);
    wire wr_term = wr_acc & (paddr == ADDR_TERM);
    wire wr_int_en = wr_acc & (paddr == ADDR_INT_EN);
    wire wr_cmd = wr_acc & (paddr == ADDR_CMD);
    wire rd_int_stat = rd_acc & (paddr == ADDR_INT_STAT);

    // Command byte as read: reserved bits and clear bit always zero
    wire [7:0] cmd_rd = {2'h0, 1'b0, cmd_chg_q, cmd_term_q, 1'b0, cmd_flip_q, 1'b0}; // R16

    wire hit = (paddr == ADDR_INT_STAT) | (paddr == ADDR_INT_EN) | (paddr == ADDR_CHARGE)
             | (paddr == ADDR_TERM) | (paddr == ADDR_VOUT_LO) | (paddr == ADDR_VOUT_HI)
             | (paddr == ADDR_RECT_LO) | (paddr == ADDR_RECT_HI) | (paddr == ADDR_IOUT_LO)
             | (paddr == ADDR_IOUT_HI) | (paddr == ADDR_TEMP_LO) | (paddr == ADDR_TEMP_HI)
             | (paddr == ADDR_FREQ_HI) | (paddr == ADDR_FREQ_LO) | (paddr == ADDR_ALIGN_H)
             | (paddr == ADDR_ALIGN_V) | (paddr == ADDR_CMD);

    wire [7:0] rd_byte =
        (paddr == ADDR_INT_STAT) ? int_stat_q :
        (paddr == ADDR_INT_EN) ? int_en_q :
        (paddr == ADDR_CHARGE) ? charge_q : // R1
        (paddr == ADDR_TERM) ? term_code_q : // R2
        (paddr == ADDR_VOUT_LO) ? vout_s[7:0] : // R7
        (paddr == ADDR_VOUT_HI) ? {4'h0, vout_s[11:8]} : // R7
        (paddr == ADDR_RECT_LO) ? rect_s[7:0] : // R9
        (paddr == ADDR_RECT_HI) ? {4'h0, rect_s[11:8]} : // R9
        (paddr == ADDR_IOUT_LO) ? iout_s[7:0] : // R10
        (paddr == ADDR_IOUT_HI) ? iout_s[15:8] : // R10
        (paddr == ADDR_TEMP_LO) ? temp_s[7:0] : // R11
        (paddr == ADDR_TEMP_HI) ? {4'h0, temp_s[11:8]} : // R11
        (paddr == ADDR_FREQ_HI) ? freq_s[15:8] : // R12
        (paddr == ADDR_FREQ_LO) ? freq_s[7:0] : // R12
        (paddr == ADDR_ALIGN_H) ? algh_s : // R13
        (paddr == ADDR_ALIGN_V) ? algv_s : // R14
        (paddr == ADDR_CMD) ? cmd_rd : 8'h00;

    // Data is latched at setup so a read-clear in the access edge cannot corrupt it
    assign prdata_d = setup ? {24'h000000, rd_byte} : prdata_q;
    assign pslverr_d = setup ? ~hit : pslverr_q;

    // ----------------------------------------
    // Host registers
    // ----------------------------------------
    assign charge_d = wr_charge ? pwdata[7:0] : charge_q; // R1
    assign term_code_d = wr_term ? pwdata[7:0] : term_code_q; // R2
    assign int_en_d = wr_int_en ? (pwdata[7:0] & INT_MASK) : int_en_q;

    // ----------------------------------------
    // Commands; hardware clears, a fresh set wins
    // ----------------------------------------
    wire pkt_done = pkt_valid_q & pkt_ready;
    wire chg_sent = pkt_done & (pkt_kind_q == PKT_CHARGE);
    wire term_sent = pkt_done & (pkt_kind_q == PKT_TERM);

    assign cmd_chg_d = (wr_cmd & pwdata[CMD_CHARGE_BIT]) | (cmd_chg_q & ~chg_sent); // R4
    assign cmd_term_d = (wr_cmd & pwdata[CMD_TERM_BIT]) | (cmd_term_q & ~term_sent); // R5
    assign cmd_flip_d = wr_cmd & pwdata[CMD_FLIP_BIT]; // R6
    assign reg_on_d = cmd_flip_q ? ~reg_on_q : reg_on_q; // R6

    // ----------------------------------------
    // Packet launcher; termination outranks charge level
    // ----------------------------------------
    wire launch = ~pkt_valid_q & (cmd_term_q | cmd_chg_q);
    wire launch_term = cmd_term_q;

    assign pkt_valid_d = pkt_valid_q ? ~pkt_ready : launch; // R4
    assign pkt_kind_d = launch ? (launch_term ? PKT_TERM : PKT_CHARGE) : pkt_kind_q; // R5
    assign pkt_data_d = launch ? (launch_term ? term_code_q : charge_q) : pkt_data_q; // R4 R5

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    wire [7:0] ev_vec;
    assign ev_vec[INT_VOUT_BIT] = cmd_flip_q;
    assign ev_vec[6:3] = 4'h0;
    assign ev_vec[INT_TEMP_BIT] = rise(ot_q, over_temp);
    assign ev_vec[INT_RECT_BIT] = rise(ov_q, rect_over_volt);
    assign ev_vec[INT_OC_BIT] = rise(oc_q, over_current);

    // A read clears only the bits it returned, so an event landing after setup survives
    wire [7:0] rd_clr = rd_int_stat ? prdata_q[7:0] : 8'h00;
    wire [7:0] clr_mask = rd_clr | {8{wr_cmd & pwdata[CMD_CLRINT_BIT]}}; // R3
    assign int_stat_d = ev_vec | (int_stat_q & ~clr_mask); // R3
    wire irq_any = |(int_stat_q & int_en_q);

    // ----------------------------------------
    // Flip-flops
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            charge_q <= CHARGE_RST;
            term_code_q <= TERM_RST;
            int_en_q <= INT_EN_RST;
            int_stat_q <= 8'h00;
            cmd_chg_q <= 1'b0;
            cmd_term_q <= 1'b0;
            cmd_flip_q <= 1'b0;
            reg_on_q <= REG_ON_RST;
        end else begin
            charge_q <= charge_d;
            term_code_q <= term_code_d;
            int_en_q <= int_en_d;
            int_stat_q <= int_stat_d;
            cmd_chg_q <= cmd_chg_d;
            cmd_term_q <= cmd_term_d;
            cmd_flip_q <= cmd_flip_d;
            reg_on_q <= reg_on_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pkt_valid_q <= 1'b0;
            pkt_kind_q <= PKT_CHARGE;
            pkt_data_q <= 8'h00;
            ot_q <= 1'b0;
            ov_q <= 1'b0;
            oc_q <= 1'b0;
            irq_b_q <= 1'b1;
        end else begin
            pkt_valid_q <= pkt_valid_d;
            pkt_kind_q <= pkt_kind_d;
            pkt_data_q <= pkt_data_d;
            ot_q <= over_temp;
            ov_q <= rect_over_volt;
            oc_q <= over_current;
            irq_b_q <= ~irq_any; // R15
        end
    end

    // Zero-wait slave: pready rises once reset has gone
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= 1'b1;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pkt_valid = pkt_valid_q;
    assign pkt_kind = pkt_kind_q;
    assign pkt_data = pkt_data_q;
    assign regulator_on = reg_on_q;
    assign irq_b = irq_b_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence clr_write_s;
        wr_cmd && pwdata[CMD_CLRINT_BIT] && (ev_vec == 8'h00);
    endsequence

    sequence released_s;
        (int_stat_q == 8'h00) ##1 irq_b_q;
    endsequence

    irq_level_a: assert property ( // R15
        @(posedge clk_sys) disable iff (!rst_b) irq_b_q == !$past(irq_any))
        else $error("interrupt pin does not follow enabled status");

    clear_release_a: assert property ( // R3
        @(posedge clk_sys) disable iff (!rst_b) clr_write_s |=> released_s)
        else $error("clear command did not release interrupt");

    charge_once_a: assert property ( // R4
        @(posedge clk_sys) disable iff (!rst_b)
        chg_sent && !(wr_cmd && pwdata[CMD_CHARGE_BIT]) |=> !cmd_chg_q && !pkt_valid_q)
        else $error("charge command not cleared after one packet");

    charge_pkt_a: assert property ( // R4
        @(posedge clk_sys) disable iff (!rst_b)
        !pkt_valid_q && cmd_chg_q && !cmd_term_q |=>
            pkt_valid_q && pkt_kind_q == PKT_CHARGE && pkt_data_q == $past(charge_q))
        else $error("charge packet wrong");

    term_pkt_a: assert property ( // R5
        @(posedge clk_sys) disable iff (!rst_b)
        !pkt_valid_q && cmd_term_q |=>
            pkt_valid_q && pkt_kind_q == PKT_TERM && pkt_data_q == $past(term_code_q))
        else $error("termination packet wrong");

    term_clear_a: assert property ( // R5
        @(posedge clk_sys) disable iff (!rst_b)
        term_sent && !(wr_cmd && pwdata[CMD_TERM_BIT]) |=> !cmd_term_q)
        else $error("termination command not cleared");

    flip_once_a: assert property ( // R6
        @(posedge clk_sys) disable iff (!rst_b)
        cmd_flip_q |=> reg_on_q != $past(reg_on_q) ##1 $stable(reg_on_q) || $past(cmd_flip_q))
        else $error("regulator flip not single");

    vout_hi_a: assert property ( // R7
        @(posedge clk_sys) disable iff (!rst_b)
        setup && paddr == ADDR_VOUT_HI |=> prdata_q[31:4] == 28'h0000000)
        else $error("voltage high byte upper bits not zero");

    charge_store_a: assert property ( // R1
        @(posedge clk_sys) disable iff (!rst_b) wr_charge |=> charge_q == $past(pwdata[7:0]))
        else $error("charge level write lost");

    cmd_reserved_a: assert property ( // R16
        @(posedge clk_sys) disable iff (!rst_b)
        setup && paddr == ADDR_CMD |=> prdata_q[7:5] == 3'h0 && !prdata_q[2] && !prdata_q[0])
        else $error("reserved command bits not zero");

    freq_order_a: assert property ( // R12
        @(posedge clk_sys) disable iff (!rst_b)
        setup && paddr == ADDR_FREQ_HI |=> prdata_q[7:0] == $past(freq_s[15:8]))
        else $error("frequency high byte not at lower address");

    term_store_a: assert property ( // R2
        @(posedge clk_sys) disable iff (!rst_b)
        wr_term |=> term_code_q == $past(pwdata[7:0]))
        else $error("termination code write lost");

    rect_hi_a: assert property ( // R9
        @(posedge clk_sys) disable iff (!rst_b)
        setup && paddr == ADDR_RECT_HI |=> prdata_q == {28'h0000000, $past(rect_s[11:8])})
        else $error("rectifier high byte wrong");

    iout_hi_a: assert property ( // R10
        @(posedge clk_sys) disable iff (!rst_b)
        setup && paddr == ADDR_IOUT_HI |=> prdata_q == {24'h000000, $past(iout_s[15:8])})
        else $error("current high byte wrong");

    align_v_a: assert property ( // R14
        @(posedge clk_sys) disable iff (!rst_b)
        setup && paddr == ADDR_ALIGN_V |=> prdata_q == {24'h000000, $past(algv_s)})
        else $error("vertical offset read wrong");

endmodule

/* verif/wrb_link_model.sv */
// Purpose: transmitter side of the packet link, one byte per handshake
// Assumes: ready is only raised while a byte is offered
// Notes: stall_n sets how many cycles the far side keeps a byte waiting
`timescale 1ns/1ns

module wrb_link_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Link
    input wire logic pkt_valid,
    input wire logic pkt_kind,
    input wire logic [7:0] pkt_data,
    output logic pkt_ready,
    // Control
    input wire logic [3:0] stall_n
);
    logic [3:0] wait_q;

    // Byte taken as offered, kind and data unaltered
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 4'h0;
            pkt_ready <= 1'b0;
        end else if (pkt_valid && !pkt_ready) begin
            wait_q <= wait_q + 4'h1;
            pkt_ready <= (wait_q >= stall_n);
        end else begin
            // Ready drops after each byte so a second one must be offered anew
            wait_q <= 4'h0;
            pkt_ready <= 1'b0;
        end
    end
endmodule

/* verif/wrb_regbank_bench.sv */
// Purpose: self-checking bench of the host register bank
// Assumes: zero-wait APB slave, link partner in wrb_link_model
// Notes: drivers note expected results in queues, monitors compare them
`timescale 1ns/1ns
`define CHK(NM, E, S) begin cmp_count++; if ((E) !== (S)) begin n_errors++; \
    $display("BAD %s exp %0h got %0h", NM, E, S); end end

module wrb_regbank_bench;
    import wrb_pkg::*;
    typedef struct {string nm; logic [32:0] v;} wrb_note_s;
    logic clk_sys = 1'b0, rst_b, psel, penable, pwrite, meas_strobe, pslverr, pready;
    logic over_temp, rect_over_volt, over_current, pkt_valid, pkt_kind, pkt_ready;
    logic regulator_on, irq_b;
    logic [11:0] paddr, out_volt_sample, rect_volt_sample, die_temp_sample;
    logic [31:0] pwdata, prdata;
    logic [15:0] out_current, freq_count, seed = 16'h005A;
    logic [7:0] coil_offset_horiz, coil_offset_vert, pkt_data, ch, tc;
    logic [3:0] stall_n;
    logic [83:0] s;
    logic [11:0] ma [12];
    logic [7:0] me [12];
    wrb_note_s rd_q [$], pkt_q [$], nt;
    int n_errors = 0, cmp_count = 0;

    always #50 clk_sys = ~clk_sys;

    wrb_regbank u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas_strobe(meas_strobe), .out_volt_sample(out_volt_sample),
        .rect_volt_sample(rect_volt_sample), .out_current(out_current),
        .die_temp_sample(die_temp_sample), .freq_count(freq_count),
        .coil_offset_horiz(coil_offset_horiz), .coil_offset_vert(coil_offset_vert),
        .over_temp(over_temp), .rect_over_volt(rect_over_volt), .over_current(over_current),
        .pkt_valid(pkt_valid), .pkt_kind(pkt_kind), .pkt_data(pkt_data),
        .pkt_ready(pkt_ready), .regulator_on(regulator_on), .irq_b(irq_b));

    wrb_link_model u_link (.clk_sys(clk_sys), .rst_b(rst_b), .pkt_valid(pkt_valid),
        .pkt_kind(pkt_kind), .pkt_data(pkt_data), .pkt_ready(pkt_ready), .stall_n(stall_n));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Request held until pready is seen high at an access edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm,
            input logic er = 1'b0);
        rd_q.push_back('{nm, {er, e}});
        apb(a, 1'b0, 32'h0);
    endtask

    task automatic new_meas();
        seed = lfsr(seed);
        out_volt_sample <= seed[11:0];
        rect_volt_sample <= seed[15:4];
        out_current <= ~seed;
        seed = lfsr(seed);
        die_temp_sample <= seed[12:1];
        freq_count <= seed;
        coil_offset_horiz <= seed[7:0] ^ 8'hA5;
        coil_offset_vert <= seed[15:8];
    endtask

    task automatic wait_pkts();
        for (int i = 0; i < 100 && pkt_q.size() > 0; i++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        `CHK("pkt_left", 0, pkt_q.size())
    endtask

    task automatic summarize();
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Monitors
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
            nt = rd_q.pop_front();
            `CHK(nt.nm, nt.v, {pslverr, prdata})
        end
        if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
            if (pkt_q.size() == 0) `CHK("pkt_extra", 1'b0, 1'b1)
            else begin
                nt = pkt_q.pop_front();
                `CHK(nt.nm, nt.v, {24'h0, pkt_kind, pkt_data})
            end
        end
    end

    initial begin
        #(100 * 20000);
        n_errors++;
        summarize();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        {psel, penable, pwrite, meas_strobe, over_temp, rect_over_volt, over_current} <= 7'h0;
        paddr <= 12'h0;
        pwdata <= 32'h0;
        stall_n <= 4'h0;
        new_meas();
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(ADDR_CHARGE, 32'h0, "charge_rst");
        rd(ADDR_TERM, 32'h0, "term_rst");
        wr_ro: apb(ADDR_VOUT_LO, 1'b1, 32'hFF);
        rd(ADDR_VOUT_LO, 32'h0, "vout_lo_ro");
        rd(ADDR_VOUT_HI, 32'h0, "vout_hi_rst");
        apb(ADDR_CMD, 1'b1, 32'hC5);
        rd(ADDR_CMD, 32'h0, "cmd_reserved");
        rd(ADDR_INT_EN, 32'h07, "int_en_rst");
        rd(ADDR_INT_STAT, 32'h0, "int_stat_rst");
        rd(12'h004, 32'h0, "unmapped", 1'b1);
        rd(12'h0E9, 32'h0, "unaligned", 1'b1);
        // Snapshot, then move the inputs to show reads stay coherent
        meas_strobe <= 1'b1;
        @(posedge clk_sys);
        meas_strobe <= 1'b0;
        s = {coil_offset_vert, coil_offset_horiz, freq_count, die_temp_sample, out_current,
            rect_volt_sample, out_volt_sample};
        new_meas();
        @(posedge clk_sys);
        ma = '{ADDR_VOUT_LO, ADDR_VOUT_HI, ADDR_RECT_LO, ADDR_RECT_HI, ADDR_IOUT_LO,
            ADDR_IOUT_HI, ADDR_TEMP_LO, ADDR_TEMP_HI, ADDR_FREQ_HI, ADDR_FREQ_LO,
            ADDR_ALIGN_H, ADDR_ALIGN_V};
        me = '{s[7:0], {4'h0, s[11:8]}, s[19:12], {4'h0, s[23:20]}, s[31:24], s[39:32],
            s[47:40], {4'h0, s[51:48]}, s[67:60], s[59:52], s[75:68], s[83:76]};
        for (int i = 0; i < 12; i++) rd(ma[i], {24'h0, me[i]}, "meas");
        // Packets, single then both at once against a slow far side
        seed = lfsr(seed);
        ch = seed[7:0];
        tc = seed[15:8];
        apb(ADDR_CHARGE, 1'b1, {24'h0, ch});
        apb(ADDR_TERM, 1'b1, {24'h0, tc});
        rd(ADDR_CHARGE, {24'h0, ch}, "charge_rw");
        rd(ADDR_TERM, {24'h0, tc}, "term_rw");
        pkt_q.push_back('{"pkt_charge", {25'h0, ch}});
        apb(ADDR_CMD, 1'b1, 32'h10);
        wait_pkts();
        rd(ADDR_CMD, 32'h0, "cmd_bit4_clr");
        stall_n <= 4'h3;
        pkt_q.push_back('{"pkt_term", {24'h0, PKT_TERM, tc}});
        pkt_q.push_back('{"pkt_charge2", {25'h0, ch}});
        apb(ADDR_CMD, 1'b1, 32'h18);
        wait_pkts();
        rd(ADDR_CMD, 32'h0, "cmd_bits_clr");
        // Regulator flip raises status bit 7; command bit 5 releases the pin
        apb(ADDR_INT_EN, 1'b1, 32'hFF);
        rd(ADDR_INT_EN, 32'h87, "int_en_rw");
        apb(ADDR_CMD, 1'b1, 32'h02);
        repeat (3) @(posedge clk_sys);
        `CHK("regulator_on", 1'b0, regulator_on)
        `CHK("irq_flip", 1'b0, irq_b)
        rd(ADDR_CMD, 32'h0, "cmd_bit1_clr");
        apb(ADDR_CMD, 1'b1, 32'h20);
        repeat (2) @(posedge clk_sys);
        `CHK("irq_release", 1'b1, irq_b)
        rd(ADDR_INT_STAT, 32'h0, "int_stat_clr");
        over_current <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK("irq_oc", 1'b0, irq_b)
        rd(ADDR_INT_STAT, 32'h01, "int_stat_oc");
        repeat (2) @(posedge clk_sys);
        `CHK("irq_read_clr", 1'b1, irq_b)
        apb(ADDR_INT_EN, 1'b1, 32'h0);
        {over_temp, rect_over_volt} <= 2'h3;
        repeat (3) @(posedge clk_sys);
        `CHK("irq_masked", 1'b1, irq_b)
        rd(ADDR_INT_STAT, 32'h06, "int_stat_masked");
        apb(ADDR_CMD, 1'b1, 32'h02);
        repeat (3) @(posedge clk_sys);
        `CHK("regulator_back", 1'b1, regulator_on)
        summarize();
    end
endmodule
